// >>> src/slspc_params.svh
/*
  Constants for the link status and serial PLL configuration registers:
  offsets, field positions, reset values and legal codes.
  Assumes inclusion by its bare name from the package and modules.
*/
// Contract
// - Buffer under/overflow sets sticky status bit 7; writing one clears it.
// - Status bit 6 shows link up, meaning elastic buffer released.
// - Status bit 5 returns sync line level: 0 asserted, 1 released.
// - SYSREF realignment sets status bit 4; writing one clears it.
// - Status bit 3 shows last SYSREF was phase consistent; writes ignored.
// - Up to seven SYSREF pulses may precede alignment; transmitter keeps sending.
// - Status bit 2 high only while every enabled SerDes PLL locks.
// - Reference clock is DAC clock divided by 6-bit divisor, reset 30h. Codes below 02h divide by 2 here.
// - 8-bit multiplier register at offset 0109h, reset value 14h.
// - Subclass 1 releases on multiframe opportunity; subclass 0 when lanes write.
// - Multiplier accepts 10h, 14h, 21h, 28h only, while link disabled.
`ifndef SLSPC_PARAMS_SVH
`define SLSPC_PARAMS_SVH

`define SLSPC_ADDR_W        16
`define SLSPC_OFF_STATUS    16'h0107
`define SLSPC_OFF_PLL_REF_DIVISOR    16'h0108
`define SLSPC_OFF_MPY       16'h0109

`define SLSPC_BIT_SLIP      7
`define SLSPC_BIT_LINKUP    6
`define SLSPC_BIT_SYNC      5
`define SLSPC_BIT_REALIGN   4
`define SLSPC_BIT_SYSREF_CONSISTENT_FLAG   3
`define SLSPC_BIT_LOCKED    2

`define SLSPC_PLL_REF_DIVISOR_W      6
`define SLSPC_PLL_REF_DIVISOR_RST    6'h30
`define SLSPC_PLL_REF_DIVISOR_MIN    6'h02
`define SLSPC_MPY_RST       8'h14
`define SLSPC_MPY_X4        8'h10
`define SLSPC_MPY_X5        8'h14
`define SLSPC_MPY_X8P25     8'h21
`define SLSPC_MPY_X10       8'h28

`define SLSPC_NUM_PLL       4
`define SLSPC_MF_W          8
`define SLSPC_RBD_W         6

`endif

// >>> src/slspc_pkg.sv
/*
  Types shared by the status and PLL configuration block.
  Assumes the params header is on the include path.
*/
`include "slspc_params.svh"

package slspc_pkg;

  // Elastic buffer release states, one-hot
  typedef enum logic [2:0] {
    SLSPC_REL_IDLE = 3'b001,
    SLSPC_REL_WAIT = 3'b010,
    SLSPC_REL_DONE = 3'b100
  } slspc_rel_e;

  typedef logic [7:0] slspc_byte_t;

endpackage

// >>> src/slspc_pll_ref_divisor.sv
/*
  Divider producing the PHY PLL reference clock from the DAC clock.
  Assumes the divisor changes only while the link is disabled.
*/
`include "slspc_params.svh"

module slspc_pll_ref_divisor
  import slspc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [`SLSPC_PLL_REF_DIVISOR_W-1:0] divisor,
  output logic                            ref_clk
);

  logic [`SLSPC_PLL_REF_DIVISOR_W-1:0] count;
  logic [`SLSPC_PLL_REF_DIVISOR_W-1:0] next_count;
  logic [`SLSPC_PLL_REF_DIVISOR_W-1:0] div_eff;
  logic                       next_ref_clk;

  // Count modulo div_eff, high for the first div_eff >> 1 counts of each period
  always_comb begin
    div_eff = (divisor < `SLSPC_PLL_REF_DIVISOR_MIN) ? `SLSPC_PLL_REF_DIVISOR_MIN : divisor;
    if (count >= div_eff - `SLSPC_PLL_REF_DIVISOR_W'(1)) begin
      next_count = '0;
    end else begin
      next_count = count + `SLSPC_PLL_REF_DIVISOR_W'(1);
    end
    next_ref_clk = (next_count < (div_eff >> 1));
  end

  // Register counter and clock
  always_ff @(posedge clk) begin
    if (reset) begin
      count   <= '0;
      ref_clk <= 1'b0;
    end else begin
      count   <= next_count;
      ref_clk <= next_ref_clk;
    end
  end

endmodule

// >>> src/slspc_regs.sv
/*
  Link status register, reference divisor and PLL multiplier registers,
  with elastic buffer release control and the reference clock divider.
  Assumes the register port is the parallel side of the serial control
  port, and that all link inputs are on the DAC clock.
*/
`include "slspc_params.svh"

module slspc_regs
  import slspc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [`SLSPC_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  output logic [7:0]                      reg_rdata,
  input  wire logic                       link_enable,
  input  wire logic                       subclass1,
  input  wire logic                       lanes_writing,
  input  wire logic [`SLSPC_MF_W-1:0]     multiframe_counter,
  input  wire logic [`SLSPC_RBD_W-1:0]    release_buffer_delay,
  input  wire logic                       buffer_fault,
  input  wire logic                       sync_line_level,
  input  wire logic                       sysref_pulse,
  input  wire logic                       sysref_realign,
  input  wire logic                       sysref_phase_ok,
  input  wire logic [`SLSPC_NUM_PLL-1:0]  pll_enable,
  input  wire logic [`SLSPC_NUM_PLL-1:0]  pll_lock,
  output logic                            buffer_release,
  output logic [`SLSPC_PLL_REF_DIVISOR_W-1:0]      pll_ref_divisor,
  output logic [7:0]                      pll_multiplier,
  output logic                            pll_ref_clk
);

  slspc_rel_e                    rel_state;
  slspc_rel_e                    next_rel_state;
  logic                          buffer_slip_flag;
  logic                          next_buffer_slip_flag;
  logic                          realign_flag;
  logic                          next_realign_flag;
  logic                          sysref_consistent_flag;
  logic                          next_sysref_consistent_flag;
  logic                          pll_locked;
  logic                          next_pll_locked;
  logic [`SLSPC_PLL_REF_DIVISOR_W-1:0]    next_pll_ref_divisor;
  logic [7:0]                    next_pll_multiplier;
  logic [7:0]                    next_reg_rdata;
  logic [7:0]                    status_word;
  logic [`SLSPC_NUM_PLL-1:0]     pll_ok;
  logic                          wr_status;
  logic                          wr_pll_ref_divisor;
  logic                          wr_mpy;
  logic                          mpy_legal;
  logic                          opportunity;

  // Per PLL: disabled PLLs count as locked
  genvar gi;
  generate
    for (gi = 0; gi < `SLSPC_NUM_PLL; gi = gi + 1) begin : g_pll
      assign pll_ok[gi] = ~pll_enable[gi] | pll_lock[gi];
    end
  endgenerate

  // Address decode and legality of multiplier codes
  assign wr_status = reg_wr && (reg_addr == `SLSPC_OFF_STATUS);
  assign wr_pll_ref_divisor = reg_wr && (reg_addr == `SLSPC_OFF_PLL_REF_DIVISOR);
  assign wr_mpy    = reg_wr && (reg_addr == `SLSPC_OFF_MPY);
  assign mpy_legal = (reg_wdata == `SLSPC_MPY_X4) ||
                     (reg_wdata == `SLSPC_MPY_X5) ||
                     (reg_wdata == `SLSPC_MPY_X8P25) ||
                     (reg_wdata == `SLSPC_MPY_X10);

  // Release opportunity when the multiframe count meets the delay
  assign opportunity = (multiframe_counter ==
                        {{(`SLSPC_MF_W-`SLSPC_RBD_W){1'b0}}, release_buffer_delay});

  // Elastic buffer release sequence
  always_comb begin
    next_rel_state = rel_state;
    unique case (rel_state)
      SLSPC_REL_IDLE: begin
        if (link_enable) begin
          next_rel_state = SLSPC_REL_WAIT;
        end
      end
      SLSPC_REL_WAIT: begin
        if (!link_enable) begin
          next_rel_state = SLSPC_REL_IDLE;
        end else if (lanes_writing && (!subclass1 || opportunity)) begin
          next_rel_state = SLSPC_REL_DONE;
        end
      end
      SLSPC_REL_DONE: begin
        if (!link_enable) begin
          next_rel_state = SLSPC_REL_IDLE;
        end
      end
      default: begin
        next_rel_state = SLSPC_REL_IDLE;
      end
    endcase
  end

  // Release state register
  always_ff @(posedge clk) begin
    if (reset) begin
      rel_state <= SLSPC_REL_IDLE;
    end else begin
      rel_state <= next_rel_state;
    end
  end

  assign buffer_release = (rel_state == SLSPC_REL_DONE);

  // Status flags: a new slip or realign event beats a same-cycle write clear
  always_comb begin
    next_buffer_slip_flag = buffer_slip_flag;
    if (wr_status && reg_wdata[`SLSPC_BIT_SLIP]) begin
      next_buffer_slip_flag = 1'b0;
    end
    if (buffer_fault) begin
      next_buffer_slip_flag = 1'b1;
    end
    next_realign_flag = realign_flag;
    if (wr_status && reg_wdata[`SLSPC_BIT_REALIGN]) begin
      next_realign_flag = 1'b0;
    end
    if (sysref_realign) begin
      next_realign_flag = 1'b1;
    end
    // Each SYSREF pulse while the link is enabled re-judges alignment; writes have no effect
    next_sysref_consistent_flag = sysref_consistent_flag;
    if (!link_enable) begin
      next_sysref_consistent_flag = 1'b0;
    end else if (sysref_pulse) begin
      next_sysref_consistent_flag = sysref_phase_ok;
    end
    next_pll_locked = &pll_ok;
  end

  // Status flag registers, cleared at reset only for a clean start
  always_ff @(posedge clk) begin
    if (reset) begin
      buffer_slip_flag       <= 1'b0;
      realign_flag           <= 1'b0;
      sysref_consistent_flag <= 1'b0;
      pll_locked             <= 1'b0;
    end else begin
      buffer_slip_flag       <= next_buffer_slip_flag;
      realign_flag           <= next_realign_flag;
      sysref_consistent_flag <= next_sysref_consistent_flag;
      pll_locked             <= next_pll_locked;
    end
  end

  // Configuration: divisor any code, multiplier legal codes while disabled
  always_comb begin
    next_pll_ref_divisor = pll_ref_divisor;
    next_pll_multiplier  = pll_multiplier;
    if (wr_pll_ref_divisor) begin
      next_pll_ref_divisor = reg_wdata[`SLSPC_PLL_REF_DIVISOR_W-1:0];
    end
    if (wr_mpy && mpy_legal && !link_enable) begin
      next_pll_multiplier = reg_wdata;
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      pll_ref_divisor <= `SLSPC_PLL_REF_DIVISOR_RST;
      pll_multiplier  <= `SLSPC_MPY_RST;
    end else begin
      pll_ref_divisor <= next_pll_ref_divisor;
      pll_multiplier  <= next_pll_multiplier;
    end
  end

  // Assemble status word; low two bits are always zero
  always_comb begin
    status_word                     = 8'h00;
    status_word[`SLSPC_BIT_SLIP]    = buffer_slip_flag;
    status_word[`SLSPC_BIT_LINKUP]  = buffer_release;
    status_word[`SLSPC_BIT_SYNC]    = sync_line_level;
    status_word[`SLSPC_BIT_REALIGN] = realign_flag;
    status_word[`SLSPC_BIT_SYSREF_CONSISTENT_FLAG] = sysref_consistent_flag;
    status_word[`SLSPC_BIT_LOCKED]  = pll_locked;
  end

  // Read mux, unmapped addresses read zero, data held between reads
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `SLSPC_OFF_STATUS: next_reg_rdata = status_word;
        `SLSPC_OFF_PLL_REF_DIVISOR: next_reg_rdata = {2'b00, pll_ref_divisor};
        `SLSPC_OFF_MPY:    next_reg_rdata = pll_multiplier;
        default:           next_reg_rdata = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Reference clock divider
  slspc_pll_ref_divisor u_pll_ref_divisor (
    .clk     (clk),
    .reset   (reset),
    .divisor (pll_ref_divisor),
    .ref_clk (pll_ref_clk)
  );

endmodule

// >>> verification/slspc_props.sv
/* Assertions on the status and PLL config register block.
   Assumes binding to slspc_regs; sees only its ports. */
`include "slspc_params.svh"
module slspc_props
  import slspc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        link_enable,
  input wire logic        subclass1,
  input wire logic        lanes_writing,
  input wire logic [7:0]  multiframe_counter,
  input wire logic [5:0]  release_buffer_delay,
  input wire logic        sync_line_level,
  input wire logic [3:0]  pll_enable,
  input wire logic [3:0]  pll_lock,
  input wire logic        buffer_release,
  input wire logic [5:0]  pll_ref_divisor,
  input wire logic [7:0]  pll_multiplier
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Status read strobe and all-locked level
  logic st_rd;
  logic all_lock;
  assign st_rd = reg_rd && reg_addr == 16'h0107;
  assign all_lock = &(~pll_enable | pll_lock);
  // Subclass 0 conditions held over enable, wait and release
  sequence s_sub0_ready;
    (link_enable && lanes_writing && !subclass1) [*3];
  endsequence
  a_sync_live: assert property (st_rd |=> reg_rdata[5] == $past(sync_line_level))
    else $error("sync level bit wrong");
  a_lock_all: assert property (st_rd && !$past(reset) |=> reg_rdata[2] == $past(all_lock, 2))
    else $error("lock bit wrong");
  a_release_drops: assert property (!link_enable |=> !buffer_release)
    else $error("release without enable");
  a_sub0_release: assert property (s_sub0_ready |-> buffer_release)
    else $error("subclass 0 release late");
  a_sub1_waits: assert property (subclass1 && !buffer_release &&
    multiframe_counter != {2'h0, release_buffer_delay} |=> !buffer_release)
    else $error("release off opportunity");
  a_mult_frozen: assert property (link_enable |=> $stable(pll_multiplier))
    else $error("multiplier changed while enabled");
  a_mult_legal: assert property (pll_multiplier inside {8'h10, 8'h14, 8'h21, 8'h28})
    else $error("multiplier code illegal");
  a_div_write: assert property (reg_wr && reg_addr == 16'h0108 |=>
    pll_ref_divisor == 6'($past(reg_wdata)))
    else $error("divisor write lost");
  a_reset_values: assert property (disable iff (1'b0) reset |=>
    pll_ref_divisor == 6'h30 && pll_multiplier == 8'h14)
    else $error("reset values wrong");
endmodule

bind slspc_regs slspc_props chk_u (.clk(clk), .reset(reset), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .link_enable(link_enable), .subclass1(subclass1), .lanes_writing(lanes_writing),
  .multiframe_counter(multiframe_counter), .release_buffer_delay(release_buffer_delay),
  .sync_line_level(sync_line_level), .pll_enable(pll_enable), .pll_lock(pll_lock),
  .buffer_release(buffer_release), .pll_ref_divisor(pll_ref_divisor),
  .pll_multiplier(pll_multiplier));

// >>> verification/slspc_regs_tb.sv
/* Self-checking bench of the status and PLL config register block.
   Assumes the transmitter model drives the link side inputs. */
module slspc_regs_tb
  import slspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} slspc_row_s;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, buffer_fault = 0;
  logic link_enable = 0, subclass1 = 0, sync_line_level = 1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, multiframe_counter, v;
  logic [5:0] release_buffer_delay = 6'h05, pll_ref_divisor;
  logic [3:0] pll_enable = 4'h0, pll_lock = 4'h0;
  logic lanes_writing, sysref_pulse, sysref_realign, sysref_phase_ok;
  logic buffer_release, pll_ref_clk;
  logic [7:0] pll_multiplier;
  int mismatches = 0, checks_done = 0;
  time t0;
  slspc_row_s rows [8] = '{'{16'h0108, 8'hc5, 8'h05}, '{16'h0108, 8'h04, 8'h04},
    '{16'h0109, 8'h10, 8'h10}, '{16'h0109, 8'h21, 8'h21}, '{16'h0109, 8'h28, 8'h28},
    '{16'h0109, 8'h33, 8'h28}, '{16'h0109, 8'h14, 8'h14}, '{16'h010a, 8'hff, 8'h00}};
  // Clock, 100 ns period
  always #50 clk = ~clk;
  slspc_regs dut_u (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_enable(link_enable), .subclass1(subclass1), .lanes_writing(lanes_writing),
    .multiframe_counter(multiframe_counter), .release_buffer_delay(release_buffer_delay),
    .buffer_fault(buffer_fault), .sync_line_level(sync_line_level),
    .sysref_pulse(sysref_pulse), .sysref_realign(sysref_realign),
    .sysref_phase_ok(sysref_phase_ok), .pll_enable(pll_enable), .pll_lock(pll_lock),
    .buffer_release(buffer_release), .pll_ref_divisor(pll_ref_divisor),
    .pll_multiplier(pll_multiplier), .pll_ref_clk(pll_ref_clk));
  slspc_tx_model #(.OK_AFTER(4)) tx_u (.clk(clk), .reset(reset),
    .link_enable(link_enable), .sysref_pulse(sysref_pulse),
    .sysref_realign(sysref_realign), .sysref_phase_ok(sysref_phase_ok),
    .lanes_writing(lanes_writing), .multiframe_counter(multiframe_counter));
  // One-cycle register write and read strobes
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Data stands from this edge; take it at the next
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (checks_done > 0 && mismatches == 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200_000;
    mismatches++;
    close_out();
  end
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(16'h0108); `CHK("divisor reset", 8'h30, v)
    rd(16'h0109); `CHK("multiplier reset", 8'h14, v)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a); `CHK("row", rows[i].e, v)
    end
    $display("register rows done");
    @(posedge pll_ref_clk);
    t0 = $time;
    @(posedge pll_ref_clk);
    `CHK("ref period", 64'd400, $time - t0)
    @(posedge clk) buffer_fault <= 1'b1;
    @(posedge clk) buffer_fault <= 1'b0;
    sync_line_level <= 1'b0;
    pll_enable <= 4'h3;
    pll_lock <= 4'h1;
    rd(16'h0107); `CHK("slip set", 1'b1, v[7])
    `CHK("sync low", 1'b0, v[5])
    `CHK("lock partial", 1'b0, v[2])
    `CHK("low bits", 2'h0, v[1:0])
    sync_line_level <= 1'b1;
    pll_lock <= 4'h3;
    rd(16'h0107); `CHK("slip sticky", 1'b1, v[7])
    `CHK("sync high", 1'b1, v[5])
    `CHK("lock all", 1'b1, v[2])
    wr(16'h0107, 8'h80);
    rd(16'h0107); `CHK("slip clear", 1'b0, v[7])
    // Fault and clear in one cycle: the fault must win
    buffer_fault <= 1'b1;
    wr(16'h0107, 8'h80);
    buffer_fault <= 1'b0;
    rd(16'h0107); `CHK("slip set wins", 1'b1, v[7])
    $display("status flags done");
    subclass1 <= 1'b1;
    link_enable <= 1'b1;
    repeat (7 * 8 + 4) @(posedge clk);
    `CHK("released", 1'b1, buffer_release)
    rd(16'h0107); `CHK("link up", 1'b1, v[6])
    `CHK("realigned", 1'b1, v[4])
    `CHK("consistent", 1'b1, v[3])
    wr(16'h0107, 8'hff);
    wr(16'h0109, 8'h10);
    rd(16'h0107); `CHK("realign clear", 1'b0, v[4])
    `CHK("consistent kept", 1'b1, v[3])
    `CHK("low bits kept", 2'h0, v[1:0])
    rd(16'h0109); `CHK("multiplier locked", 8'h14, v)
    link_enable <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("release drop", 1'b0, buffer_release)
    subclass1 <= 1'b0;
    link_enable <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK("sub0 release", 1'b1, buffer_release)
    $display("link release done");
    // Mid-run reset brings back divisor and link state
    link_enable <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    `CHK("reset drops link", 1'b0, buffer_release)
    rd(16'h0108); `CHK("divisor re-reset", 8'h30, v)
    @(posedge pll_ref_clk);
    t0 = $time;
    @(posedge pll_ref_clk);
    `CHK("ref period reset", 64'd4800, $time - t0)
    $display("mid-run reset done");
    close_out();
  end
endmodule

// >>> verification/slspc_tx_model.sv
/* Transmitter side model: SYSREF pulses, lane writing, multiframe count.
   Assumes one clock shared with the block. */
module slspc_tx_model
  import slspc_pkg::*;
#(parameter int OK_AFTER = 4)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       link_enable,
  output logic            sysref_pulse,
  output logic            sysref_realign,
  output logic            sysref_phase_ok,
  output logic            lanes_writing,
  output logic [7:0]      multiframe_counter
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] tick;
  logic [3:0] pulses;
  // Pulse every 8 cycles while enabled; phase is judged good from pulse OK_AFTER on
  always_ff @(posedge clk) begin
    multiframe_counter <= reset ? 8'h00 : {4'h0, multiframe_counter[3:0] + 4'h1};
    tick <= (reset || !link_enable) ? 3'h0 : tick + 3'h1;
    sysref_pulse <= link_enable && tick == 3'h7;
    sysref_realign <= link_enable && tick == 3'h7 && pulses == 4'h0;
    sysref_phase_ok <= 32'(pulses) >= OK_AFTER - 1;
    lanes_writing <= link_enable && pulses != 4'h0;
    if (reset || !link_enable) begin
      pulses <= 4'h0;
    end else if (tick == 3'h7 && pulses != 4'hf) begin
      pulses <= pulses + 4'h1;
    end
  end
endmodule
